// ==== nvm_write_read_control.v ====
// Behaviour
// R1: the write-done flag is set on every completed write, whatever the interrupt enables say.
// R2: write-done sits at bit 4 of the flag register, reads 1 after a write and holds until software writes 0.
// R3: all other bits of the flag register read as zero.
// R4: with write-enable (control bit 2) clear, no write is started; software sets it first. The code only needs bit 2 in the control write that sets bit 1.
// R5: write-start (bit 1) launches a write, hardware clears it at the end, a software 0 does nothing.
// R6: software clears write-done before it sets write-start.
// R7: a data-memory write erases the byte at address_low, then programs it with data_low.
// R8: during a data-memory write the core keeps running; write-done is set at the end.
// R9: a program-memory write stalls the core from start to completion, then sets write-done.
// R10: a program-memory write erases and programs the word at address_high:address_low with data_high:data_low.
// R11: an external clear or watchdog reset during a write sets write-abort (bit 3).
// R12: those warm resets leave data, address and memory_space_select untouched.
// R13: software clears write-abort after power-on and tests it after other resets.
// R14: read-start (bit 0) launches a read, hardware clears it, a software 0 does nothing.
// R15: memory_space_select (bit 7) picks program memory when 1, data memory when 0.
`include "nvm_map.vh"
`default_nettype none
module nvm_write_read_control (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // warm reset requests, asynchronous
   input wire external_clear_reset,
   input wire watchdog_timer,
   // memory array port
   output wire mem_req,
   output wire [1:0] mem_op,
   output reg mem_space,
   output reg [15:0] mem_addr,
   output reg [15:0] mem_wdata,
   input wire mem_done,
   input wire [15:0] mem_rdata,
   // core side
   output reg core_stall,
   output wire irq
);
   localparam S_IDLE = 4'b0001;
   localparam S_ERASE = 4'b0010;
   localparam S_PROG = 4'b0100;
   localparam S_READ = 4'b1000;

   reg [3:0] state_reg;
   reg memory_space_select_reg;
   reg write_abort_flag_reg;
   reg write_enable_reg;
   reg write_start_reg;
   reg read_start_reg;
   reg write_done_flag_reg;
   reg [7:0] address_low_reg;
   reg [7:0] address_high_reg;
   reg [7:0] data_low_reg;
   reg [7:0] data_high_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_mask_reg;
   reg [31:0] read_mux;
   wire clr_sync;
   wire wdt_sync;
   wire warm;
   wire [9:0] idx;
   wire acc;
   wire wr;
   wire rd;
   wire mapped;
   wire write_busy;
   wire write_fin;
   wire read_fin;
   wire abort_evt;
   wire [2:0] irq_set;
   wire [2:0] irq_clr;

   // ==========================================
   // warm reset synchronisers
   sync_two_flop u_clr_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(external_clear_reset),
      .dout(clr_sync)
   );

   sync_two_flop u_wdt_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(watchdog_timer),
      .dout(wdt_sync)
   );

   assign warm = clr_sync | wdt_sync;

   // ==========================================
   // apb decode
   assign idx = paddr[11:2];
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign mapped = (idx == `IDX_FLAG) || (idx == `IDX_CTRL) ||
                   (idx == `IDX_ADDR_LOW) || (idx == `IDX_ADDR_HIGH) ||
                   (idx == `IDX_DATA_LOW) || (idx == `IDX_DATA_HIGH) ||
                   (idx == `IDX_IRQ_STATUS) || (idx == `IDX_IRQ_MASK);
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // ==========================================
   // status events
   assign write_busy = (state_reg == S_ERASE) || (state_reg == S_PROG);
   assign write_fin = (state_reg == S_PROG) && mem_done && !warm;
   assign read_fin = (state_reg == S_READ) && mem_done && !warm;
   assign abort_evt = warm && write_busy;

   // ==========================================
   // memory port
   assign mem_req = (state_reg != S_IDLE);
   assign mem_op = (state_reg == S_ERASE) ? `OP_ERASE :
                   (state_reg == S_PROG) ? `OP_PROGRAM : `OP_READ;

   // ==========================================
   // read data, captured in the setup phase
   always @* begin
      case (idx)
         `IDX_FLAG: begin
            read_mux = `ZERO_BUS;
            read_mux[`FLAG_WRITE_DONE] = write_done_flag_reg; // R2 R3
         end
         `IDX_CTRL: begin
            read_mux = `ZERO_BUS;
            read_mux[`CTRL_SPACE] = memory_space_select_reg;
            read_mux[`CTRL_ABORT] = write_abort_flag_reg;
            read_mux[`CTRL_ENABLE] = write_enable_reg;
            read_mux[`CTRL_WSTART] = write_start_reg;
            read_mux[`CTRL_RSTART] = read_start_reg;
         end
         `IDX_ADDR_LOW: read_mux = {24'h000000, address_low_reg};
         `IDX_ADDR_HIGH: read_mux = {24'h000000, address_high_reg};
         `IDX_DATA_LOW: read_mux = {24'h000000, data_low_reg};
         `IDX_DATA_HIGH: read_mux = {24'h000000, data_high_reg};
         `IDX_IRQ_STATUS: read_mux = {29'h0000000, irq_status_reg};
         `IDX_IRQ_MASK: read_mux = {29'h0000000, irq_mask_reg};
         default: read_mux = `ZERO_BUS;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `ZERO_BUS;
      end else if (psel && !penable && !pwrite) begin
         prdata <= read_mux;
      end
   end

   // ==========================================
   // address, data and space select
   // only power-on reset clears these
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_low_reg <= `RST_BYTE;
         address_high_reg <= `RST_BYTE;
         data_low_reg <= `RST_BYTE;
         data_high_reg <= `RST_BYTE;
         memory_space_select_reg <= 1'b0;
      end else begin
         if (wr && idx == `IDX_ADDR_LOW) begin
            address_low_reg <= pwdata[7:0];
         end
         if (wr && idx == `IDX_ADDR_HIGH) begin
            address_high_reg <= pwdata[7:0];
         end
         if (wr && idx == `IDX_CTRL) begin
            memory_space_select_reg <= pwdata[`CTRL_SPACE];
         end
         if (read_fin) begin
            data_low_reg <= mem_rdata[7:0];
            if (mem_space) begin // R15
               data_high_reg <= mem_rdata[15:8];
            end
         end else begin
            if (wr && idx == `IDX_DATA_LOW) begin
               data_low_reg <= pwdata[7:0];
            end
            if (wr && idx == `IDX_DATA_HIGH) begin
               data_high_reg <= pwdata[7:0];
            end
         end
      end
   end

   // ==========================================
   // sequencer and control bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         write_abort_flag_reg <= 1'b0;
         write_enable_reg <= 1'b0;
         write_start_reg <= 1'b0;
         read_start_reg <= 1'b0;
         core_stall <= 1'b0;
         mem_space <= 1'b0;
         mem_addr <= `RST_WORD;
         mem_wdata <= `RST_WORD;
      end else if (warm) begin
         // R12: address, data and space select are left alone
         if (write_busy) begin
            write_abort_flag_reg <= 1'b1; // R11
         end
         write_enable_reg <= 1'b0;
         write_start_reg <= 1'b0;
         read_start_reg <= 1'b0;
         core_stall <= 1'b0;
         state_reg <= S_IDLE;
      end else begin
         if (wr && idx == `IDX_CTRL) begin
            write_enable_reg <= pwdata[`CTRL_ENABLE];
            write_abort_flag_reg <= pwdata[`CTRL_ABORT];
         end
         case (state_reg)
            S_IDLE: begin
               if (wr && idx == `IDX_CTRL) begin
                  mem_space <= pwdata[`CTRL_SPACE];
                  if (pwdata[`CTRL_SPACE]) begin // R10
                     mem_addr <= {address_high_reg, address_low_reg};
                     mem_wdata <= {data_high_reg, data_low_reg};
                  end else begin // R7
                     mem_addr <= {8'h00, address_low_reg};
                     mem_wdata <= {8'h00, data_low_reg};
                  end
                  if (pwdata[`CTRL_WSTART] && pwdata[`CTRL_ENABLE]) begin // R4 R5
                     write_start_reg <= 1'b1;
                     core_stall <= pwdata[`CTRL_SPACE]; // R8 R9
                     state_reg <= S_ERASE;
                  end else if (pwdata[`CTRL_RSTART]) begin // R14
                     read_start_reg <= 1'b1;
                     state_reg <= S_READ;
                  end
               end
            end
            S_ERASE: begin
               if (mem_done) begin // R7 R10
                  state_reg <= S_PROG;
               end
            end
            S_PROG: begin
               if (mem_done) begin
                  write_start_reg <= 1'b0; // R5
                  core_stall <= 1'b0; // R9
                  state_reg <= S_IDLE;
               end
            end
            S_READ: begin
               if (mem_done) begin
                  read_start_reg <= 1'b0; // R14
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // write-done flag, set wins over software clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_done_flag_reg <= 1'b0;
      end else if (write_fin) begin
         write_done_flag_reg <= 1'b1; // R1 R8 R9
      end else if (wr && idx == `IDX_FLAG) begin
         write_done_flag_reg <= pwdata[`FLAG_WRITE_DONE]; // R2
      end
   end

   // ==========================================
   // interrupt status, clear on read, mask
   assign irq_set = {abort_evt, read_fin, write_fin};
   // clear only the bits that the read returned, so a late event is kept
   assign irq_clr = (rd && idx == `IDX_IRQ_STATUS) ? prdata[`IRQ_W-1:0] : `RST_IRQ;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= `RST_IRQ;
         irq_mask_reg <= `RST_IRQ;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
         if (wr && idx == `IDX_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ==== nvm_map.vh ====
`ifndef NVM_MAP_VH
`define NVM_MAP_VH
// ==========================================
// register indexes (byte address = 4 * index)
`define IDX_FLAG 10'h00D
`define IDX_CTRL 10'h18C
`define IDX_ADDR_LOW 10'h190
`define IDX_ADDR_HIGH 10'h191
`define IDX_DATA_LOW 10'h192
`define IDX_DATA_HIGH 10'h193
`define IDX_IRQ_STATUS 10'h194
`define IDX_IRQ_MASK 10'h195
// ==========================================
// flag register fields
`define FLAG_WRITE_DONE 4
// ==========================================
// control register fields
`define CTRL_SPACE 7
`define CTRL_ABORT 3
`define CTRL_ENABLE 2
`define CTRL_WSTART 1
`define CTRL_RSTART 0
// ==========================================
// interrupt status and mask fields
`define IRQ_WRITE 0
`define IRQ_READ 1
`define IRQ_ABORT 2
`define IRQ_W 3
// ==========================================
// memory operation codes
`define OP_ERASE 2'h1
`define OP_PROGRAM 2'h2
`define OP_READ 2'h3
// ==========================================
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_IRQ 3'h0
`define ZERO_BUS 32'h00000000
`endif

// ==== sync_two_flop.v ====
`default_nettype none
// ==========================================
// two-stage level synchroniser
module sync_two_flop (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // level in and out
   input wire din,
   output reg dout
);
   reg meta_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== nvm_write_read_control_asserts.sv ====
`include "nvm_map.vh"
`default_nettype none
// ====================
// port checker
module nvm_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // warm resets
   input wire logic external_clear_reset,
   input wire logic watchdog_timer,
   // array and core
   input wire logic mem_req,
   input wire logic [1:0] mem_op,
   input wire logic mem_space,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic mem_done,
   input wire logic core_stall
);
   logic [2:0] warm_reg;
   logic quiet, go;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) warm_reg <= 3'h0;
      else warm_reg <= {warm_reg[1:0], external_clear_reset | watchdog_timer};
   end
   // no warm reset near this edge
   assign quiet = warm_reg == 3'h0 && !external_clear_reset && !watchdog_timer;
   assign go = psel && penable && pwrite && paddr[11:2] == `IDX_CTRL && !mem_req && quiet;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   start_blocked_a: assert property (go && !pwdata[2] && !pwdata[0] |=> !mem_req)
      else $error("write ran without enable");
   write_launch_a: assert property (go && pwdata[2] && pwdata[1] |=> mem_req && mem_op == `OP_ERASE)
      else $error("write did not start");
   read_launch_a: assert property (go && !pwdata[1] && pwdata[0] |=> mem_req && mem_op == `OP_READ)
      else $error("read did not start");
   erase_then_prog_a: assert property (quiet && mem_req && mem_op == `OP_ERASE && mem_done
      |=> mem_req && mem_op == `OP_PROGRAM) else $error("program did not follow erase");
   stall_space_a: assert property (mem_req && mem_op != `OP_READ |-> core_stall == mem_space)
      else $error("stall does not match space");
   stall_release_a: assert property (quiet && mem_req && mem_op == `OP_PROGRAM && mem_done
      |=> !mem_req && !core_stall) else $error("write did not finish");
   target_hold_a: assert property (mem_req && $past(mem_req) |-> $stable(mem_addr) && $stable(mem_space)
      && $stable(mem_wdata)) else $error("target moved in mid operation");
   data_byte_a: assert property (mem_req && !mem_space && mem_op != `OP_READ
      |-> mem_addr[15:8] == 8'h00 && mem_wdata[15:8] == 8'h00) else $error("data write not byte wide");
   flag_unused_a: assert property (psel && penable && !pwrite && paddr[11:2] == `IDX_FLAG
      |-> prdata[31:5] == 27'h0 && prdata[3:0] == 4'h0) else $error("unused flag bits set");
   prog_done_c: cover property (mem_req && mem_op == `OP_PROGRAM && mem_space && mem_done);
   read_done_c: cover property (mem_req && mem_op == `OP_READ && mem_done);
   abort_c: cover property (mem_req && mem_op != `OP_READ && external_clear_reset);
endmodule
bind nvm_write_read_control nvm_checker nvm_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .external_clear_reset(external_clear_reset), .watchdog_timer(watchdog_timer), .mem_req(mem_req),
   .mem_op(mem_op), .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_done(mem_done), .core_stall(core_stall));
`default_nettype wire

// ==== nvm_array_model.sv ====
`default_nettype none
// ====================
// memory array model
module nvm_array_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // array port
   input wire logic mem_req,
   input wire logic [15:0] mem_addr,
   input wire logic [3:0] lat,
   output logic mem_done,
   output logic [15:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         mem_done <= 1'b0;
         mem_rdata <= 16'h0000;
      end else begin
         mem_done <= 1'b0;
         // read data is only valid with the done pulse
         mem_rdata <= ~mem_rdata;
         cnt <= 4'h0;
         if (mem_req && !mem_done && cnt >= lat) begin
            mem_done <= 1'b1;
            mem_rdata <= mem_addr ^ 16'hA5C3;
         end else if (mem_req && !mem_done) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test_nvm_write_read_control.sv ====
`include "nvm_map.vh"
`default_nettype none
module test_nvm_write_read_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, external_clear_reset = 0, watchdog_timer = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, mem_req, mem_space, mem_done, core_stall, irq;
   logic [1:0] mem_op;
   logic [15:0] mem_addr, mem_wdata, mem_rdata;
   logic [3:0] lat = 4'h1;
   int error_cnt = 0, checked = 0, cyc = 0;
   nvm_write_read_control nvm_write_read_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_clear_reset(external_clear_reset), .watchdog_timer(watchdog_timer),
      .mem_req(mem_req), .mem_op(mem_op), .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_done(mem_done), .mem_rdata(mem_rdata), .core_stall(core_stall), .irq(irq));
   nvm_array_model nvm_array_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_addr(mem_addr), .lat(lat), .mem_done(mem_done), .mem_rdata(mem_rdata));
   // ====================
   // shared tasks
   task automatic stop_test;
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [9:0] i, input logic [31:0] e);
      apb(1'b0, i, 8'h00);
      chk({8'h00, rd}, {8'h00, e});
   endtask
   task automatic wait_idle;
      while (mem_req !== 1'b0) @(posedge pclk);
      @(posedge pclk);
   endtask
   // ====================
   // scenarios
   task automatic t_no_enable;
      rchk(`IDX_FLAG, 32'h0);
      apb(1'b0, 10'h3FF, 8'h00);
      chk(err, 1'b1);
      apb(1'b1, `IDX_IRQ_MASK, 8'h07);
      apb(1'b1, `IDX_CTRL, 8'h02);
      chk(mem_req, 1'b0);
      rchk(`IDX_CTRL, 32'h0);
   endtask
   task automatic t_data_write;
      apb(1'b1, `IDX_FLAG, 8'h00);
      apb(1'b1, `IDX_ADDR_LOW, 8'h3C);
      apb(1'b1, `IDX_ADDR_HIGH, 8'h07);
      apb(1'b1, `IDX_DATA_LOW, 8'h5A);
      apb(1'b1, `IDX_DATA_HIGH, 8'h2B);
      apb(1'b1, `IDX_CTRL, 8'h06);
      chk({mem_space, core_stall, mem_addr, mem_wdata}, {2'b00, 16'h003C, 16'h005A});
      wait_idle;
      chk(irq, 1'b1);
      rchk(`IDX_FLAG, 32'h10);
      rchk(`IDX_CTRL, 32'h04);
      rchk(`IDX_IRQ_STATUS, 32'h1);
      chk(irq, 1'b0);
   endtask
   task automatic t_prog_write;
      lat <= 4'h6;
      apb(1'b1, `IDX_FLAG, 8'h00);
      rchk(`IDX_FLAG, 32'h0);
      apb(1'b1, `IDX_CTRL, 8'h86);
      chk({core_stall, mem_space, mem_addr, mem_wdata}, {2'b11, 16'h073C, 16'h2B5A});
      apb(1'b1, `IDX_CTRL, 8'h84);
      chk(mem_req & core_stall, 1'b1);
      wait_idle;
      chk(core_stall, 1'b0);
      rchk(`IDX_FLAG, 32'h10);
      rchk(`IDX_IRQ_STATUS, 32'h1);
   endtask
   task automatic t_read;
      apb(1'b1, `IDX_CTRL, 8'h81);
      chk(mem_op, `OP_READ);
      wait_idle;
      rchk(`IDX_DATA_LOW, 32'hFF);
      rchk(`IDX_DATA_HIGH, 32'hA2);
      rchk(`IDX_CTRL, 32'h80);
      rchk(`IDX_IRQ_STATUS, 32'h2);
   endtask
   task automatic t_warm(input logic src);
      lat <= 4'hF;
      apb(1'b1, `IDX_CTRL, 8'h86);
      repeat (3) @(posedge pclk);
      if (src) watchdog_timer <= 1'b1;
      else external_clear_reset <= 1'b1;
      repeat (4) @(posedge pclk);
      watchdog_timer <= 1'b0;
      external_clear_reset <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(mem_req | core_stall, 1'b0);
      rchk(`IDX_CTRL, 32'h88);
      rchk(`IDX_ADDR_LOW, 32'h3C);
      rchk(`IDX_DATA_HIGH, 32'hA2);
      rchk(`IDX_IRQ_STATUS, 32'h4);
      apb(1'b1, `IDX_CTRL, 8'h80);
   endtask
   // ====================
   // clock, timeout and main sequence
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 3000) begin
         error_cnt++;
         stop_test;
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_no_enable;
      t_data_write;
      t_prog_write;
      t_read;
      t_warm(1'b0);
      t_warm(1'b1);
      stop_test;
   end
endmodule
`default_nettype wire
